// file: inc/dsm_defs.vh
// Constants for the DRAM access and refresh state machine
`ifndef DSM_DEFS_VH
`define DSM_DEFS_VH

// =====================================================
// Refresh timing
`define DSM_CLK_MHZ        25
`define DSM_REF_PRESET     9'h185
`define DSM_REF_WIDTH      9
`define DSM_RAS_MIN_NS     85
`define DSM_CLK_PERIOD_NS  40

// =====================================================
// State codes, one-hot, 15 states
`define DSM_NSTATE         15
`define DSM_S_IDLE         15'h0001
`define DSM_S_IROW         15'h0002
`define DSM_S_ICOL         15'h0004
`define DSM_S_IACC         15'h0008
`define DSM_S_DROW         15'h0010
`define DSM_S_DCOL         15'h0020
`define DSM_S_DACC         15'h0040
`define DSM_S_WROW         15'h0080
`define DSM_S_WACC         15'h0100
`define DSM_S_WPF          15'h0200
`define DSM_S_WPS          15'h0400
`define DSM_S_PRE          15'h0800
`define DSM_S_RQ1          15'h1000
`define DSM_S_RQ2          15'h2000
`define DSM_S_RQ3          15'h4000

`endif

// file: src/dsm_dram_ctrl.v
// DRAM access and refresh control state machine
// Contract
// - Fifteen-state machine drives all memory controls
// - Idle default; refresh beats instruction/data
// - Idle doubles as precharge between sequences
// - Instr row: RAS, ack, latch, no ready
// - Instr column asserts CAS, then access
// - Instr access: enable/ready follow burst
// - Leave instr access on new address/data/refresh
// - Precharge drops acks and RAS, then idle
// - Precharge separates preempted burst from data
// - Data read mirrors instr; exits on refresh/suspend
// - Write: CAS strobes, ready one cycle earlier
// - Two write-preempt states finish pending writes
// - CAS during idle when refresh pending
// - Refresh RAS three cycles in total
// - Nine-bit counter presets at 389, wraps
// - Request flag set on preset, cleared by ack
// - Refresh preempts data access
// - Refresh ack only when no burst ack
// - Refresh states follow in successive cycles
// - Access recognised only when selected, valid, no refresh
`timescale 1ns/1ps
`include "dsm_defs.vh"
module dsm_dram_ctrl #(
  parameter [8:0] REF_PRESET = `DSM_REF_PRESET
)
(
  // Clock and reset
  input  wire core_clk_i,
  input  wire nrst_i,
  input  wire sync_rst_i,
  // Instruction request side
  input  wire instr_req_i,
  input  wire instr_new_addr_i,
  input  wire instr_space_ok_i,
  input  wire instr_addr_match_i,
  input  wire instr_burst_req_i,
  // Data request side
  input  wire data_req_i,
  input  wire data_write_i,
  input  wire data_space_ok_i,
  input  wire data_addr_match_i,
  input  wire data_burst_req_i,
  input  wire test_ctrl_i,
  // Data path buffer, receiver side
  input  wire wbuf_ready_i,
  // Memory strobes
  output reg  ras_o,
  output reg  cas_o,
  output reg  addr_latch_close_o,
  // Bus responses
  output reg  instr_burst_ack_o,
  output reg  data_burst_ack_o,
  output reg  instr_ready_o,
  output reg  instr_output_enable_o,
  output reg  data_ready_o,
  output reg  data_output_enable_o,
  // Refresh status
  output reg  refresh_acknowledge_o,
  output reg  refresh_busy_o,
  // Write buffer handoff
  output reg  wbuf_valid_o
);

  // =====================================================
  // Declarations
  reg  [14:0] state_reg;
  reg  [14:0] state_next;
  reg  [1:0]  wbuf_cnt_reg;
  wire        refresh_request_flag;
  wire        instr_block_select;
  wire        data_block_select;
  wire        data_burst_ack_internal;
  wire        refresh_clear;
  wire        wr_accept;
  wire        refresh_ack_set;

  // =====================================================
  // Refresh timer
  dsm_refresh_timer #(
    .PRESET (REF_PRESET)
  ) u_timer (
    .core_clk_i             (core_clk_i),
    .nrst_i                 (nrst_i),
    .sync_rst_i             (sync_rst_i),
    .clear_i                (refresh_clear),
    .refresh_request_flag_o (refresh_request_flag)
  );

  assign refresh_clear = refresh_acknowledge_o & state_reg[12];

  // =====================================================
  // Address recognition
  assign instr_block_select = instr_req_i & instr_space_ok_i & instr_addr_match_i
                              & ~test_ctrl_i & ~refresh_request_flag;
  assign data_block_select  = data_req_i & data_space_ok_i & data_addr_match_i
                              & ~test_ctrl_i & ~refresh_request_flag;
  assign data_burst_ack_internal = data_burst_ack_o | (state_reg[9] | state_reg[10]);

  // Refresh acknowledge may start once both bursts are idle
  assign refresh_ack_set = refresh_request_flag & ~instr_burst_ack_o & ~data_burst_ack_internal
                           & state_next[0] & ~refresh_acknowledge_o;

  // Write word accepted into the one-entry buffer this cycle, write access only
  assign wr_accept = data_ready_o & data_write_i & state_reg[8];

  // =====================================================
  // Next state
  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      `DSM_S_IDLE:
      begin
        if (refresh_acknowledge_o)
          state_next = `DSM_S_RQ1;
        else if (instr_block_select)
          state_next = `DSM_S_IROW;
        else if (data_block_select)
          state_next = data_write_i ? `DSM_S_WROW : `DSM_S_DROW;
      end
      `DSM_S_IROW: state_next = `DSM_S_ICOL;
      `DSM_S_ICOL: state_next = `DSM_S_IACC;
      `DSM_S_IACC:
      begin
        if (instr_new_addr_i | data_block_select | refresh_request_flag)
          state_next = `DSM_S_PRE;
      end
      `DSM_S_DROW: state_next = `DSM_S_DCOL;
      `DSM_S_DCOL: state_next = `DSM_S_DACC;
      `DSM_S_DACC:
      begin
        if (refresh_request_flag | ~data_burst_req_i)
          state_next = `DSM_S_PRE;
      end
      `DSM_S_WROW: state_next = `DSM_S_WACC;
      `DSM_S_WACC:
      begin
        if (refresh_request_flag)
          state_next = `DSM_S_WPF;
        else if (~data_burst_req_i & wbuf_cnt_reg == 2'd0)
          state_next = `DSM_S_PRE;
      end
      `DSM_S_WPF: state_next = `DSM_S_WPS;
      `DSM_S_WPS: state_next = `DSM_S_PRE;
      `DSM_S_PRE: state_next = `DSM_S_IDLE;
      `DSM_S_RQ1: state_next = `DSM_S_RQ2;
      `DSM_S_RQ2: state_next = `DSM_S_RQ3;
      `DSM_S_RQ3: state_next = `DSM_S_IDLE;
      default:    state_next = `DSM_S_IDLE;
    endcase
  end

  // =====================================================
  // State register and registered outputs
  always @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      state_reg             <= `DSM_S_IDLE;
      wbuf_cnt_reg          <= 2'd0;
      ras_o                 <= 1'b0;
      cas_o                 <= 1'b0;
      addr_latch_close_o    <= 1'b0;
      instr_burst_ack_o     <= 1'b0;
      data_burst_ack_o      <= 1'b0;
      instr_ready_o         <= 1'b0;
      instr_output_enable_o <= 1'b0;
      data_ready_o          <= 1'b0;
      data_output_enable_o  <= 1'b0;
      refresh_acknowledge_o <= 1'b0;
      refresh_busy_o        <= 1'b0;
      wbuf_valid_o          <= 1'b0;
    end
    else if (sync_rst_i)
    begin
      state_reg             <= `DSM_S_IDLE;
      wbuf_cnt_reg          <= 2'd0;
      ras_o                 <= 1'b0;
      cas_o                 <= 1'b0;
      addr_latch_close_o    <= 1'b0;
      instr_burst_ack_o     <= 1'b0;
      data_burst_ack_o      <= 1'b0;
      instr_ready_o         <= 1'b0;
      instr_output_enable_o <= 1'b0;
      data_ready_o          <= 1'b0;
      data_output_enable_o  <= 1'b0;
      refresh_acknowledge_o <= 1'b0;
      refresh_busy_o        <= 1'b0;
      wbuf_valid_o          <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      // Refresh acknowledge set when idle of bursts, held to end of sequence
      if (refresh_acknowledge_o)
        refresh_acknowledge_o <= ~state_reg[14];
      else
        refresh_acknowledge_o <= refresh_ack_set;
      refresh_busy_o <= state_next[12] | state_next[13] | state_next[14];
      // RAS active through row, access and refresh states
      ras_o <= |(state_next & (`DSM_S_IROW | `DSM_S_ICOL | `DSM_S_IACC | `DSM_S_DROW
                 | `DSM_S_DCOL | `DSM_S_DACC | `DSM_S_WROW | `DSM_S_WACC | `DSM_S_WPF
                 | `DSM_S_WPS | `DSM_S_RQ1 | `DSM_S_RQ2 | `DSM_S_RQ3));
      // CAS: read columns, write strobes, refresh setup in idle
      cas_o <= (|(state_next & (`DSM_S_ICOL | `DSM_S_IACC | `DSM_S_DCOL | `DSM_S_DACC)))
               | ((state_next[8] | state_next[9] | state_next[10]) & wr_accept)
               | refresh_ack_set
               | state_next[12] | state_next[13] | state_next[14];
      addr_latch_close_o <= ~(state_next[0] | state_next[11]);
      instr_burst_ack_o  <= state_next[1] | state_next[2] | state_next[3];
      data_burst_ack_o   <= |(state_next & (`DSM_S_DROW | `DSM_S_DCOL | `DSM_S_DACC
                            | `DSM_S_WROW | `DSM_S_WACC));
      instr_ready_o         <= state_next[3] & instr_burst_req_i;
      instr_output_enable_o <= state_next[3] & instr_burst_req_i;
      data_ready_o          <= (state_next[6] & data_burst_req_i)
                               | (state_next[8] & data_burst_req_i & wbuf_ready_i);
      data_output_enable_o  <= state_next[6] & data_burst_req_i;
      wbuf_valid_o          <= wr_accept;
      if (wr_accept & ~cas_o)
        wbuf_cnt_reg <= 2'd1;
      else if (~wr_accept & cas_o)
        wbuf_cnt_reg <= 2'd0;
    end
  end

endmodule // dsm_dram_ctrl

// file: src/dsm_refresh_timer.v
// Refresh interval counter and refresh request flag
`timescale 1ns/1ps
`include "dsm_defs.vh"
module dsm_refresh_timer #(
  parameter [8:0] PRESET = `DSM_REF_PRESET
)
(
  // Clock and reset
  input  wire       core_clk_i,
  input  wire       nrst_i,
  input  wire       sync_rst_i,
  // Refresh handshake
  input  wire       clear_i,
  output reg        refresh_request_flag_o
);

  reg [8:0] refresh_count_reg;

  // =====================================================
  // Counter with synchronous preset at terminal count
  always @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      refresh_count_reg      <= 9'h000;
      refresh_request_flag_o <= 1'b0;
    end
    else if (sync_rst_i)
    begin
      refresh_count_reg      <= 9'h000;
      refresh_request_flag_o <= 1'b0;
    end
    else
    begin
      if (refresh_count_reg == PRESET)
      begin
        refresh_count_reg      <= 9'h000;
        refresh_request_flag_o <= 1'b1;
      end
      else
      begin
        refresh_count_reg <= refresh_count_reg + 9'h001;
        if (clear_i)
          refresh_request_flag_o <= 1'b0;
      end
    end
  end

endmodule // dsm_refresh_timer

// file: verif/dsm_cpu_model.sv
// Processor bus model that raises and holds requests
`timescale 1ns/1ps
module dsm_cpu_model
(
  // Clock and command
  input  wire       core_clk_i,
  input  wire       go_i,
  input  wire [1:0] kind_i,
  // Acknowledges
  input  wire       instr_burst_ack_i,
  input  wire       data_burst_ack_i,
  // Request lines
  output reg        instr_req_o,
  output reg        data_req_o,
  output reg        data_write_o,
  output wire       qual_o,
  output wire       busy_o
);
  reg tog_reg = 1'b0;
  reg iack_reg = 1'b0;
  reg dack_reg = 1'b0;
  assign busy_o = instr_req_o | data_req_o;
  // Qualifiers toggle while no request is held
  assign qual_o = busy_o | tog_reg;
  initial
  begin
    instr_req_o = 1'b0;
    data_req_o = 1'b0;
    data_write_o = 1'b0;
  end
  always @(posedge core_clk_i)
  begin
    tog_reg <= ~tog_reg;
    iack_reg <= instr_burst_ack_i;
    dack_reg <= data_burst_ack_i;
    if (!busy_o)
      data_write_o <= ~data_write_o;
    if (go_i)
    begin
      instr_req_o <= (kind_i == 2'h0);
      data_req_o <= (kind_i != 2'h0);
      data_write_o <= (kind_i == 2'h2);
    end
    else
    begin
      // Held until a fresh acknowledge is sampled, not one left from an earlier access
      if (instr_burst_ack_i & ~iack_reg)
        instr_req_o <= 1'b0;
      if (data_burst_ack_i & ~dack_reg)
        data_req_o <= 1'b0;
    end
  end
endmodule // dsm_cpu_model

// file: verif/dsm_ctrl_assertions.sv
// Concurrent checks on the DRAM control state machine ports
`timescale 1ns/1ps
module dsm_ctrl_assertions
(
  // Clock, reset and request terms
  input logic core_clk_i, nrst_i, sync_rst_i, test_ctrl_i,
  input logic instr_burst_req_i, data_burst_req_i, data_write_i,
  // Controller outputs
  input logic ras_o, cas_o, addr_latch_close_o, instr_burst_ack_o, data_burst_ack_o,
  input logic instr_ready_o, instr_output_enable_o, data_ready_o, data_output_enable_o,
  input logic refresh_acknowledge_o, refresh_busy_o, wbuf_valid_o
);
  default clocking dc @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  // ==========================================
  // Sequences
  sequence s_irow;
    ras_o && addr_latch_close_o && !instr_ready_o && !instr_output_enable_o;
  endsequence
  sequence s_icol;
    cas_o && !instr_ready_o;
  endsequence
  sequence s_refresh;
    (refresh_busy_o && ras_o)[*3] ##1 !refresh_busy_o;
  endsequence
  // ==========================================
  // Properties
  AST_IROW: assert property ($rose(instr_burst_ack_o) |-> s_irow ##1 s_icol)
    else $error("instruction row or column step wrong");
  AST_PRE: assert property ($fell(instr_burst_ack_o) |-> (!data_burst_ack_o && !ras_o) [*2])
    else $error("precharge did not drop strobes");
  AST_REF3: assert property ($rose(refresh_busy_o) |-> s_refresh)
    else $error("refresh length wrong");
  AST_CBR: assert property ($rose(refresh_busy_o) |-> $past(cas_o) && !$past(ras_o))
    else $error("no column strobe before refresh");
  AST_REFRESH_ACKNOWLEDGE: assert property ($rose(refresh_acknowledge_o) |->
    !instr_burst_ack_o && !data_burst_ack_o ##1 refresh_acknowledge_o [*3])
    else $error("refresh acknowledge wrong");
  AST_DROW: assert property ($rose(data_burst_ack_o) |-> ras_o && !data_output_enable_o)
    else $error("data row step wrong");
  AST_NOBURST: assert property (refresh_busy_o |-> !instr_burst_ack_o && !data_burst_ack_o)
    else $error("burst ack during refresh");
  AST_SPACE: assert property (test_ctrl_i |=> !$rose(instr_burst_ack_o) && !$rose(data_burst_ack_o))
    else $error("access taken under test control");
  AST_RESET: assert property (sync_rst_i |=> !ras_o && !cas_o && !instr_burst_ack_o && !refresh_acknowledge_o)
    else $error("reset left outputs active");
  AST_IACC: assert property (instr_burst_ack_o && $past(instr_burst_ack_o) && $past(instr_burst_ack_o, 2) |->
    instr_ready_o == $past(instr_burst_req_i) && instr_output_enable_o == instr_ready_o)
    else $error("instruction ready does not follow burst request");
  AST_DOE: assert property (data_output_enable_o |->
    data_ready_o && data_burst_ack_o && $past(data_burst_req_i))
    else $error("data output enable outside data access");
  AST_WBUF: assert property (data_ready_o && !data_output_enable_o && data_write_i && !sync_rst_i |=>
    wbuf_valid_o)
    else $error("accepted write word not handed on");
endmodule // dsm_ctrl_assertions
bind dsm_dram_ctrl dsm_ctrl_assertions u_chk (.*);

// file: verif/testbench.sv
// Self-checking testbench for the DRAM control state machine
`timescale 1ns/1ps
module testbench;
  localparam [8:0] PRE = 9'h03f;
  reg        core_clk_i, nrst_i, sync_rst_i, go, tst, ibr, dbr, wrdy;
  reg  [1:0] kind;
  reg  [2:0] lv, ev;
  reg  [2:0] q[$];
  wire       ireq, dreq, dwr, qual, busy, ras, cas, alc, iack, dack, irdy, ioe, data_ready, data_output_enable, rfa, rfb;
  integer    n_fail = 0, n_compared = 0, seed = 32'habe0b728, cyc = 0, t0 = 0, t1, i, n;

  dsm_dram_ctrl #(.REF_PRESET(PRE)) DUT (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .sync_rst_i(sync_rst_i),
    .instr_req_i(ireq), .instr_new_addr_i(ireq), .instr_space_ok_i(qual), .instr_addr_match_i(qual),
    .instr_burst_req_i(ibr), .data_req_i(dreq), .data_write_i(dwr), .data_space_ok_i(qual),
    .data_addr_match_i(qual), .data_burst_req_i(dbr), .test_ctrl_i(tst), .wbuf_ready_i(wrdy), .ras_o(ras),
    .cas_o(cas), .addr_latch_close_o(alc), .instr_burst_ack_o(iack), .data_burst_ack_o(dack),
    .instr_ready_o(irdy), .instr_output_enable_o(ioe), .data_ready_o(data_ready), .data_output_enable_o(data_output_enable),
    .refresh_acknowledge_o(rfa), .refresh_busy_o(rfb), .wbuf_valid_o());
  dsm_cpu_model u_cpu (.core_clk_i(core_clk_i), .go_i(go), .kind_i(kind), .instr_burst_ack_i(iack),
    .data_burst_ack_i(dack), .instr_req_o(ireq), .data_req_o(dreq), .data_write_o(dwr), .qual_o(qual),
    .busy_o(busy));

  initial
  begin
    core_clk_i = 1'b0;
    forever #2.5 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i)
    {ibr, dbr, wrdy} <= #1 $random(seed);

  task chk(input ok, input string m);
    begin
      n_compared = n_compared + 1;
      if (ok !== 1'b1)
      begin
        $display("[FAIL] %0t %0s", $time, m);
        n_fail = n_fail + 1;
      end
    end
  endtask
  // Event monitor: rises of instr ack, data ack, refresh busy
  always @(posedge core_clk_i)
  begin
    cyc = cyc + 1;
    ev = {rfb, dack, iack} & ~lv;
    lv = {rfb, dack, iack};
    if (ev !== 3'h0)
    begin
      chk(q.size() != 0 && q[0] === ev, "unexpected event");
      if (q.size() != 0)
        void'(q.pop_front());
    end
  end
  task tick(input integer k);
    begin
      repeat (k) @(posedge core_clk_i);
      #1;
    end
  endtask
  task refr;
    begin
      q.push_back(3'h4);
      for (i = 0; i < 300 && rfb !== 1'b1; i = i + 1)
        tick(1);
      t0 = cyc;
      for (i = 0; i < 300 && rfb === 1'b1; i = i + 1)
        tick(1);
    end
  endtask
  task issue(input [1:0] k, input blk);
    begin
      kind = k;
      go = 1'b1;
      tst = blk;
      tick(1);
      go = 1'b0;
      if (blk)
        tick(10);
      tst = 1'b0;
      q.push_back(k == 2'h0 ? 3'h1 : 3'h2);
      for (i = 0; i < 300 && busy !== 1'b0; i = i + 1)
        tick(1);
      $display("access kind %0d block %0d done", k, blk);
    end
  endtask
  task end_sim;
    begin
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask

  initial
  begin
    repeat (30000) @(posedge core_clk_i);
    chk(1'b0, "timeout");
    end_sim;
  end
  initial
  begin
    {nrst_i, sync_rst_i, go, tst, kind, ibr, dbr, wrdy, lv} = 0;
    tick(6);
    nrst_i = 1'b1;
    refr;
    t1 = t0;
    refr;
    chk(t0 - t1 == PRE + 1, "refresh interval");
    for (n = 0; n < 3; n = n + 1)
    begin
      refr;
      issue(n, 1'b0);
    end
    refr;
    issue(2'h0, 1'b1);
    refr;
    issue(2'h0, 1'b0);
    issue(2'h0, 1'b0);
    issue(2'h1, 1'b0);
    refr;
    issue(2'h0, 1'b0);
    sync_rst_i = 1'b1;
    tick(1);
    sync_rst_i = 1'b0;
    chk({ras, cas, alc, iack, dack, irdy, ioe, data_ready, data_output_enable, rfa, rfb} === 11'h000, "sync reset");
    for (n = 0; n < 8; n = n + 1)
    begin
      refr;
      issue($unsigned($random(seed)) % 3, 1'b0);
    end
    refr;
    chk(q.size() == 0, "events missing");
    end_sim;
  end
endmodule // testbench
